// *** rtl/i2c_mapper_pkg.sv ***
// Shared constants and carriers for the control channel I2C mapper.
package i2c_mapper_pkg;
   // -----------------------------------------------------------------
   // Clock and register map
   // -----------------------------------------------------------------
   localparam int unsigned CLK_MHZ       = 125;
   localparam logic [7:0]  OFS_CTRL      = 8'h06;
   localparam logic [7:0]  OFS_REMOTE    = 8'h07;
   localparam logic [7:0]  OFS_PHYS_0    = 8'h08;
   localparam logic [7:0]  OFS_PHYS_1    = 8'h09;
   localparam logic [7:0]  RST_CTRL      = 8'h00;
   localparam logic [7:0]  RST_REMOTE    = 8'h18;
   localparam logic [7:0]  RST_PHYS      = 8'h00;
   localparam logic [7:0]  CTRL_WR_MASK  = 8'h5F;
   localparam int          BIT_SEQ_ERR   = 7;
   localparam int          BIT_SEQ_CLR   = 6;
   localparam int          BIT_DLY_LO    = 3;
   localparam int          BIT_WR_BLOCK  = 2;
   localparam int          BIT_WD_FAST   = 1;
   localparam int          BIT_WD_DIS    = 0;
   localparam int          BIT_HOLD_ADDR = 0;
   localparam int          ALIAS_SLOTS   = 2;

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   function automatic int unsigned ns_to_cyc(input int unsigned ns);
      return (ns * CLK_MHZ + 999) / 1000;
   endfunction
   localparam int unsigned DLY_BASE_NS      = 250;
   localparam int unsigned DLY_STEP_NS      = 50;
   localparam int unsigned DLY_MAX_CYC      = ns_to_cyc(DLY_BASE_NS + 3 * DLY_STEP_NS);
   localparam int unsigned WD_FAST_MS       = 50;
   localparam int unsigned WD_SLOW_MS       = 1000;
   localparam int unsigned BUS_FREE_MS      = 1000;
   localparam int unsigned WD_FAST_CYC      = WD_FAST_MS * CLK_MHZ * 1000;
   localparam int unsigned WD_SLOW_CYC      = WD_SLOW_MS * CLK_MHZ * 1000;
   localparam int unsigned BUS_FREE_CYC     = BUS_FREE_MS * CLK_MHZ * 1000;
   localparam int unsigned RECOVER_HALF_NS  = 5000;
   localparam int unsigned RECOVER_HALF_CYC = ns_to_cyc(RECOVER_HALF_NS);
   localparam int unsigned RECOVER_PULSES   = 9;

   // -----------------------------------------------------------------
   // Carriers
   // -----------------------------------------------------------------
   typedef struct packed {
      logic       valid;
      logic       write;
      logic       remote;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;
   typedef struct packed {
      logic       valid;
      logic [7:0] rdata;
   } reg_rsp_t;
   typedef struct packed {
      logic       valid;
      logic [6:0] addr;
   } txn_t;
   typedef struct packed {
      logic       valid;
      logic       routed;
      logic [6:0] addr;
   } fwd_t;
endpackage

// *** rtl/bus_watchdog.sv ***
// I2C bus watchdog: free-bus detection and nine-clock recovery.
`timescale 1ns/100ps
module bus_watchdog
   import i2c_mapper_pkg::*;
#(
   parameter int unsigned FAST_CYC = WD_FAST_CYC,
   parameter int unsigned SLOW_CYC = WD_SLOW_CYC,
   parameter int unsigned FREE_CYC = BUS_FREE_CYC,
   parameter int unsigned HALF_CYC = RECOVER_HALF_CYC
) (
   input  wire logic sys_clk,
   input  wire logic reset_n,
   input  wire logic scl_pin,
   input  wire logic sda_pin,
   input  wire logic enable,
   input  wire logic fast,
   output logic      scl_oe,
   output logic      bus_free,
   output logic      recovering
);
   typedef enum logic [1:0] {WD_IDLE = 2'b01, WD_RECOVER = 2'b10} wd_state_t;
   wd_state_t   state;
   logic [2:0]  scl_sync;
   logic [2:0]  sda_sync;
   logic        scl_f;
   logic        sda_f;
   logic        activity;
   logic [31:0] idle;
   logic [31:0] half;
   logic [4:0]  edges;
   logic        expire;

   // ----------------------------------------------------------------
   // Pin synchronisers and change detection
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         scl_sync <= 3'h7;
         sda_sync <= 3'h7;
         scl_f    <= 1'b1;
         sda_f    <= 1'b1;
      end else begin
         scl_sync <= {scl_sync[1:0], scl_pin};
         sda_sync <= {sda_sync[1:0], sda_pin};
         if (scl_sync[1] == scl_sync[2]) scl_f <= scl_sync[1];
         if (sda_sync[1] == sda_sync[2]) sda_f <= sda_sync[1];
      end
   end
   assign activity = (scl_sync[1] == scl_sync[2] && scl_sync[1] != scl_f) ||
                     (sda_sync[1] == sda_sync[2] && sda_sync[1] != sda_f);

   // ----------------------------------------------------------------
   // Idle timer
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!reset_n || !enable || activity || state != WD_IDLE) begin
         idle <= 32'h0000_0000;
      end else if (idle != 32'hFFFF_FFFF) begin
         idle <= idle + 32'h0000_0001;
      end
   end
   assign expire = enable && !activity && state == WD_IDLE &&
                   idle == (fast ? FAST_CYC : SLOW_CYC) - 1;

   always_ff @(posedge sys_clk) begin
      if (!reset_n) bus_free <= 1'b0;
      else bus_free <= enable && !activity && sda_f && idle == FREE_CYC - 1;
   end

   // ----------------------------------------------------------------
   // Recovery clocking
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         state      <= WD_IDLE;
         scl_oe     <= 1'b0;
         recovering <= 1'b0;
         half       <= 32'h0000_0000;
         edges      <= 5'h00;
      end else begin
         case (state)
            WD_IDLE: begin
               if (expire && !sda_f) begin
                  state      <= WD_RECOVER;
                  scl_oe     <= 1'b1;
                  recovering <= 1'b1;
                  half       <= 32'h0000_0000;
                  edges      <= 5'h00;
               end
            end
            WD_RECOVER: begin
               if (half == HALF_CYC - 1) begin
                  half <= 32'h0000_0000;
                  if (edges == 5'(2 * RECOVER_PULSES - 1)) begin
                     state      <= WD_IDLE;
                     scl_oe     <= 1'b0;
                     recovering <= 1'b0;
                  end else begin
                     edges  <= edges + 5'h01;
                     scl_oe <= ~scl_oe;
                  end
               end else begin
                  half <= half + 32'h0000_0001;
               end
            end
            default: state <= WD_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   wd_disable_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      !enable |=> idle == 32'h0000_0000 && !$rose(recovering))
      else $error("watchdog ran while disabled");
   recover_low_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      $rose(recovering) |-> $past(!sda_f) && scl_oe)
      else $error("recovery began with SDA high");
   recover_len_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      $fell(recovering) |-> $past(edges) == 5'd17)
      else $error("recovery did not give nine pulses");
   recover_c: cover property (@(posedge sys_clk) disable iff (!reset_n) $fell(recovering));
endmodule // bus_watchdog

// *** rtl/channel_mapper.sv ***
// Control channel register bank, SDA delay, address remap and watchdog.
`timescale 1ns/100ps
// Functional notes
// - Forward sequence error sets read-only flag
// - Clear bit is writable, not self-clearing
// - Bits 4:3 set SDA delay 250-400 ns
// - Bit 2 refuses remote writes to registers
// - Bit 1 picks 50 ms or 1 s
// - Bit 0 disables the bus watchdog
// - SDA high idle 1 s means bus free
// - SDA low at expiry gives nine SCL pulses
// - Serializer address field; zero blocks access
// - Auto-load serializer address while not held
// - Hold bit freezes the software-written address
// - Alias hit replaces address with physical address
// - Second slot remaps likewise; bit 0 reserved
// - Zero alias match disables its slot
module channel_mapper
   import i2c_mapper_pkg::*;
#(
   parameter int unsigned FAST_CYC = WD_FAST_CYC,
   parameter int unsigned SLOW_CYC = WD_SLOW_CYC,
   parameter int unsigned FREE_CYC = BUS_FREE_CYC,
   parameter int unsigned HALF_CYC = RECOVER_HALF_CYC
) (
   input  wire logic     sys_clk,
   input  wire logic     reset_n,
   input  wire reg_req_t reg_req,
   output reg_rsp_t      reg_rsp,
   output logic          write_refused,
   input  wire logic     seq_error_event,
   input  wire logic     fwd_id_valid,
   input  wire logic [6:0] fwd_id,
   input  wire logic [6:0] alias_match_0,
   input  wire logic [6:0] alias_match_1,
   input  wire txn_t     txn,
   output fwd_t          fwd,
   input  wire logic     sda_drive_raw,
   output logic          sda_o,
   output logic          sda_oe,
   input  wire logic     scl_pin,
   input  wire logic     sda_pin,
   output logic          scl_o,
   output logic          scl_oe,
   output logic          bus_free,
   output logic          recovering,
   output logic          seq_error_flag,
   output logic [6:0]    remote_addr,
   output logic          remote_enable
);
   logic [6:0]            ctrl;
   logic                  hold_remote_address;
   logic [6:0]            phys [ALIAS_SLOTS];
   logic [6:0]            match [ALIAS_SLOTS];
   logic [ALIAS_SLOTS-1:0] hit;
   logic                  wr_ok;
   logic [1:0]            dly_code;
   logic [5:0]            dly_tap;
   logic [DLY_MAX_CYC-2:0] dly_pipe;
   logic [7:0]            next_rdata;
   fwd_t                  next_fwd;

   assign match[0] = alias_match_0;
   assign match[1] = alias_match_1;

   // ----------------------------------------------------------------
   // Register writes
   // ----------------------------------------------------------------
   assign wr_ok = reg_req.valid && reg_req.write &&
                  !(reg_req.remote && ctrl[BIT_WR_BLOCK]);

   always_ff @(posedge sys_clk) begin
      if (!reset_n) write_refused <= 1'b0;
      else write_refused <= reg_req.valid && reg_req.write && reg_req.remote &&
                            ctrl[BIT_WR_BLOCK];
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) ctrl <= RST_CTRL[6:0];
      else if (wr_ok && reg_req.addr == OFS_CTRL)
         ctrl <= reg_req.wdata[6:0] & CTRL_WR_MASK[6:0];
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) seq_error_flag <= RST_CTRL[BIT_SEQ_ERR];
      else if (ctrl[BIT_SEQ_CLR]) seq_error_flag <= 1'b0;
      else if (seq_error_event) seq_error_flag <= 1'b1;
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         remote_addr         <= RST_REMOTE[7:1];
         hold_remote_address <= RST_REMOTE[BIT_HOLD_ADDR];
      end else if (wr_ok && reg_req.addr == OFS_REMOTE) begin
         remote_addr         <= reg_req.wdata[7:1];
         hold_remote_address <= reg_req.wdata[BIT_HOLD_ADDR];
      end else if (fwd_id_valid && !hold_remote_address) begin
         remote_addr <= fwd_id;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) remote_enable <= |RST_REMOTE[7:1];
      else remote_enable <= remote_addr != 7'h00;
   end

   generate
      for (genvar n = 0; n < ALIAS_SLOTS; n++) begin : g_slot
         always_ff @(posedge sys_clk) begin
            if (!reset_n) phys[n] <= RST_PHYS[7:1];
            else if (wr_ok && reg_req.addr == OFS_PHYS_0 + 8'(n))
               phys[n] <= reg_req.wdata[7:1];
         end
         assign hit[n] = match[n] != 7'h00 && txn.addr == match[n];
      end
   endgenerate

   // ----------------------------------------------------------------
   // Register reads
   // ----------------------------------------------------------------
   always_comb begin
      if (reg_req.addr == OFS_CTRL) begin
         next_rdata = {seq_error_flag, ctrl};
      end else if (reg_req.addr == OFS_REMOTE) begin
         next_rdata = {remote_addr, hold_remote_address};
      end else if (reg_req.addr == OFS_PHYS_0) begin
         next_rdata = {phys[0], 1'b0};
      end else if (reg_req.addr == OFS_PHYS_1) begin
         next_rdata = {phys[1], 1'b0};
      end else begin
         next_rdata = 8'h00;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) reg_rsp <= '0;
      else reg_rsp <= '{valid: reg_req.valid && !reg_req.write, rdata: next_rdata};
   end

   // ----------------------------------------------------------------
   // Address remap
   // ----------------------------------------------------------------
   always_comb begin
      next_fwd = '{valid: txn.valid, routed: 1'b0, addr: txn.addr};
      if (hit[0]) begin
         next_fwd.routed = 1'b1;
         next_fwd.addr   = phys[0];
      end else if (hit[1]) begin
         next_fwd.routed = 1'b1;
         next_fwd.addr   = phys[1];
      end else if (remote_addr != 7'h00 && txn.addr == remote_addr) begin
         next_fwd.routed = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) fwd <= '0;
      else fwd <= next_fwd;
   end

   // ----------------------------------------------------------------
   // SDA output delay
   // ----------------------------------------------------------------
   // The pipe and the output flop together give the full delay count.
   assign dly_code = ctrl[BIT_DLY_LO+1:BIT_DLY_LO];
   assign dly_tap  = 6'(ns_to_cyc(DLY_BASE_NS + DLY_STEP_NS * 32'(dly_code)) - 2);

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         dly_pipe <= '0;
         sda_oe   <= 1'b0;
         sda_o    <= 1'b0;
         scl_o    <= 1'b0;
      end else begin
         dly_pipe <= {dly_pipe[DLY_MAX_CYC-3:0], sda_drive_raw};
         sda_oe   <= dly_pipe[dly_tap];
         sda_o    <= 1'b0;
         scl_o    <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Bus watchdog
   // ----------------------------------------------------------------
   bus_watchdog #(
      .FAST_CYC (FAST_CYC),
      .SLOW_CYC (SLOW_CYC),
      .FREE_CYC (FREE_CYC),
      .HALF_CYC (HALF_CYC)
   ) u_watchdog (
      .sys_clk    (sys_clk),
      .reset_n    (reset_n),
      .scl_pin    (scl_pin),
      .sda_pin    (sda_pin),
      .enable     (!ctrl[BIT_WD_DIS]),
      .fast       (ctrl[BIT_WD_FAST]),
      .scl_oe     (scl_oe),
      .bus_free   (bus_free),
      .recovering (recovering)
   );

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   seq_set_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      seq_error_event && !ctrl[BIT_SEQ_CLR] |=> seq_error_flag)
      else $error("sequence error not recorded");
   seq_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      ctrl[BIT_SEQ_CLR] [*2] |-> !seq_error_flag)
      else $error("flag set while clear held");
   clr_keep_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      !(wr_ok && reg_req.addr == OFS_CTRL) |=> $stable(ctrl[BIT_SEQ_CLR]))
      else $error("clear bit changed by itself");
   delay_tap_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (dly_code == 2'b00 |-> dly_tap == 6'd30) and (dly_code == 2'b11 |-> dly_tap == 6'd48))
      else $error("SDA delay tap wrong");
   remote_block_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      reg_req.valid && reg_req.write && reg_req.remote && ctrl[BIT_WR_BLOCK]
      |=> $stable(ctrl) && ($stable(remote_addr) || $past(fwd_id_valid)) &&
          $stable(hold_remote_address) && write_refused)
      else $error("remote write reached a register");
   autoload_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      fwd_id_valid && !hold_remote_address && !(wr_ok && reg_req.addr == OFS_REMOTE)
      |=> remote_addr == $past(fwd_id))
      else $error("serializer address not loaded");
   freeze_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      hold_remote_address && !(wr_ok && reg_req.addr == OFS_REMOTE) |=> $stable(remote_addr))
      else $error("held address changed");
   remap_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      txn.valid && alias_match_0 != 7'h00 && txn.addr == alias_match_0
      |=> fwd.valid && fwd.routed && fwd.addr == $past(phys[0]))
      else $error("alias 0 not remapped");
   zero_block_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      txn.valid && txn.addr == 7'h00 |=> !fwd.routed)
      else $error("zero address was routed");
   seq_c: cover property (@(posedge sys_clk) disable iff (!reset_n) $rose(seq_error_flag));
   refuse_c: cover property (@(posedge sys_clk) disable iff (!reset_n) write_refused);
   remap_c: cover property (@(posedge sys_clk) disable iff (!reset_n) fwd.valid && fwd.routed);
endmodule // channel_mapper

// *** sim/i2c_bus_model.sv ***
// Open-drain I2C bus with pull-ups and a local host that can hold lines low.
`timescale 1ns/100ps
module i2c_bus_model (
   input  wire logic sys_clk,
   input  wire logic scl_oe,
   input  wire logic sda_oe,
   input  wire logic host_scl_low,
   input  wire logic host_sda_low,
   input  wire logic count_clear,
   output logic      scl_pin,
   output logic      sda_pin,
   output int        low_phases
);
   logic scl_prev;

   // -----------------------------------------------------------------
   // Wired-AND lines
   // -----------------------------------------------------------------
   // A released line floats up to the pull-up level.
   assign scl_pin = !(scl_oe || host_scl_low);
   assign sda_pin = !(sda_oe || host_sda_low);

   // -----------------------------------------------------------------
   // Recovery clock counter
   // -----------------------------------------------------------------
   // Each falling edge of SCL opens one low phase seen by the host.
   always_ff @(posedge sys_clk) begin
      scl_prev <= scl_pin;
      if (count_clear) begin
         low_phases <= 0;
      end else if (scl_prev && !scl_pin) begin
         low_phases <= low_phases + 1;
      end
   end
endmodule // i2c_bus_model

// *** sim/control_channel_i2c_mapper_tb.sv ***
// Self-checking testbench for the control channel I2C mapper.
`timescale 1ns/100ps
module control_channel_i2c_mapper_tb;
   import i2c_mapper_pkg::*;
   localparam int FAST = 200;
   localparam int SLOW = 400;
   localparam int FREE = 400;
   localparam int HALF = 4;
   logic       sys_clk = 1'b0;
   logic       reset_n = 1'b0;
   reg_req_t   reg_req = '0;
   reg_rsp_t   reg_rsp;
   logic       write_refused, seq_error_event = 1'b0, fwd_id_valid = 1'b0;
   logic [6:0] fwd_id = 7'h00, alias_match_0 = 7'h21, alias_match_1 = 7'h21;
   txn_t       txn = '0;
   fwd_t       fwd;
   logic       sda_drive_raw = 1'b0, sda_o, sda_oe, scl_pin, sda_pin, scl_o, scl_oe;
   logic       bus_free, recovering, seq_error_flag, remote_enable;
   logic [6:0] remote_addr;
   logic       host_sda_low = 1'b0, count_clear = 1'b1, refused;
   int         low_phases, error_cnt = 0, check_count = 0, cyc = 0, n, base;

   channel_mapper #(.FAST_CYC(FAST), .SLOW_CYC(SLOW), .FREE_CYC(FREE), .HALF_CYC(HALF))
      channel_mapper_inst (.sys_clk(sys_clk), .reset_n(reset_n), .reg_req(reg_req),
      .reg_rsp(reg_rsp), .write_refused(write_refused), .seq_error_event(seq_error_event),
      .fwd_id_valid(fwd_id_valid), .fwd_id(fwd_id), .alias_match_0(alias_match_0),
      .alias_match_1(alias_match_1), .txn(txn), .fwd(fwd), .sda_drive_raw(sda_drive_raw),
      .sda_o(sda_o), .sda_oe(sda_oe), .scl_pin(scl_pin), .sda_pin(sda_pin), .scl_o(scl_o),
      .scl_oe(scl_oe), .bus_free(bus_free), .recovering(recovering),
      .seq_error_flag(seq_error_flag), .remote_addr(remote_addr),
      .remote_enable(remote_enable));

   i2c_bus_model i2c_bus_model_inst (.sys_clk(sys_clk), .scl_oe(scl_oe), .sda_oe(sda_oe),
      .host_scl_low(1'b0), .host_sda_low(host_sda_low), .count_clear(count_clear),
      .scl_pin(scl_pin), .sda_pin(sda_pin), .low_phases(low_phases));

   // -----------------------------------------------------------------
   // Clock, timeout and report
   // -----------------------------------------------------------------
   initial begin
      forever #4 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         wrap_up();
      end
   end

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // -----------------------------------------------------------------
   // Access tasks
   // -----------------------------------------------------------------
   // Inputs always move one nanosecond after the rising edge.
   task automatic tick();
      @(posedge sys_clk);
      #1;
   endtask

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic ok(input bit cond, input string what);
      chk8({7'h00, cond}, 8'h01, what);
   endtask

   task automatic reg_write(input logic [7:0] a, input logic [7:0] d, input logic r);
      tick();
      reg_req = '{valid: 1'b1, write: 1'b1, remote: r, addr: a, wdata: d};
      tick();
      reg_req = '0;
      refused = (write_refused === 1'b1);
      tick();
      refused = refused || (write_refused === 1'b1);
   endtask

   task automatic reg_read(input logic [7:0] a, input logic [7:0] e);
      int k;
      k = 0;
      tick();
      reg_req = '{valid: 1'b1, write: 1'b0, remote: 1'b0, addr: a, wdata: 8'h00};
      tick();
      reg_req = '0;
      while (reg_rsp.valid !== 1'b1 && k < 3) begin
         tick();
         k++;
      end
      ok(reg_rsp.valid === 1'b1 && k == 0, "read answer");
      chk8(reg_rsp.rdata, e, "register read");
   endtask

   task automatic remap(input logic [6:0] a, input logic r, input logic [6:0] e);
      int k;
      k = 0;
      tick();
      txn = '{valid: 1'b1, addr: a};
      tick();
      txn = '0;
      while (fwd.valid !== 1'b1 && k < 2) begin
         tick();
         k++;
      end
      ok(fwd.valid === 1'b1 && k == 0, "remap answer");
      chk8({7'h00, fwd.routed}, {7'h00, r}, "routed flag");
      chk8({1'b0, fwd.addr}, {1'b0, e}, "forwarded address");
   endtask

   task automatic seq_pulse();
      tick();
      seq_error_event = 1'b1;
      tick();
      seq_error_event = 1'b0;
      tick();
   endtask

   task automatic learn_id(input logic [6:0] id);
      tick();
      fwd_id_valid = 1'b1;
      fwd_id = id;
      tick();
      fwd_id_valid = 1'b0;
   endtask

   task automatic wait_hi(input int w, input int lim, output int k);
      k = 0;
      while (k < lim && !((w == 0 && bus_free === 1'b1) || (w == 1 && recovering === 1'b1)
             || (w == 2 && sda_oe === 1'b1))) begin
         tick();
         k++;
      end
   endtask

   // -----------------------------------------------------------------
   // Test sequence
   // -----------------------------------------------------------------
   initial begin
      repeat (6) tick();
      reset_n = 1'b1;
      count_clear = 1'b0;
      reg_read(OFS_CTRL, RST_CTRL);
      reg_read(OFS_REMOTE, RST_REMOTE);
      reg_read(OFS_PHYS_0, RST_PHYS);
      reg_read(OFS_PHYS_1, RST_PHYS);
      reg_read(8'h0A, 8'h00);
      chk8({1'b0, remote_addr}, 8'h0C, "remote address");
      reg_write(OFS_PHYS_0, 8'hA5, 1'b0);
      reg_read(OFS_PHYS_0, 8'hA4);
      reg_write(OFS_PHYS_1, 8'h33, 1'b0);
      reg_read(OFS_PHYS_1, 8'h32);
      remap(7'h21, 1'b1, 7'h52);
      alias_match_0 = 7'h22;
      remap(7'h21, 1'b1, 7'h19);
      alias_match_0 = 7'h00;
      alias_match_1 = 7'h00;
      remap(7'h00, 1'b0, 7'h00);
      remap(7'h0C, 1'b1, 7'h0C);
      alias_match_0 = 7'h21;
      seq_pulse();
      ok(seq_error_flag === 1'b1, "sequence flag set");
      reg_read(OFS_CTRL, 8'h80);
      reg_write(OFS_CTRL, 8'h40, 1'b0);
      ok(seq_error_flag === 1'b0, "sequence flag cleared");
      seq_pulse();
      ok(seq_error_flag === 1'b0, "flag held clear");
      reg_read(OFS_CTRL, 8'h40);
      reg_write(OFS_CTRL, 8'hA0, 1'b0);
      reg_read(OFS_CTRL, 8'h00);
      seq_pulse();
      ok(seq_error_flag === 1'b1, "flag set again");
      reg_write(OFS_CTRL, 8'h04, 1'b0);
      reg_write(OFS_PHYS_0, 8'hFE, 1'b1);
      ok(refused, "remote write refused");
      reg_read(OFS_PHYS_0, 8'hA4);
      remap(7'h21, 1'b1, 7'h52);
      reg_write(OFS_PHYS_0, 8'h10, 1'b0);
      reg_read(OFS_PHYS_0, 8'h10);
      reg_write(OFS_CTRL, 8'h00, 1'b0);
      reg_write(OFS_PHYS_0, 8'hFE, 1'b1);
      ok(!refused, "remote write taken");
      reg_read(OFS_PHYS_0, 8'hFE);
      learn_id(7'h2A);
      reg_read(OFS_REMOTE, 8'h54);
      reg_write(OFS_REMOTE, 8'h31, 1'b0);
      learn_id(7'h2B);
      reg_read(OFS_REMOTE, 8'h31);
      remap(7'h18, 1'b1, 7'h18);
      reg_write(OFS_REMOTE, 8'h01, 1'b0);
      repeat (2) tick();
      ok(remote_enable === 1'b0, "serializer access blocked");
      remap(7'h00, 1'b0, 7'h00);
      for (int c = 0; c < 4; c++) begin
         reg_write(OFS_CTRL, 8'(c << BIT_DLY_LO), 1'b0);
         sda_drive_raw = 1'b1;
         wait_hi(2, 80, n);
         if (c == 0) base = n;
         ok(base >= 32 && base <= 34 && n - base == 6 * c, "sda delay");
         sda_drive_raw = 1'b0;
         repeat (60) tick();
      end
      host_sda_low = 1'b1;
      repeat (3) tick();
      host_sda_low = 1'b0;
      wait_hi(0, FREE + 40, n);
      ok(n >= FREE - 2 && n <= FREE + 12, "bus free time");
      for (int s = 0; s < 2; s++) begin
         reg_write(OFS_CTRL, s ? 8'h00 : 8'h02, 1'b0);
         count_clear = 1'b1;
         host_sda_low = 1'b1;
         tick();
         count_clear = 1'b0;
         wait_hi(1, SLOW + 40, n);
         ok(n >= (s ? SLOW : FAST) - 3 && n <= (s ? SLOW : FAST) + 12, "expiry");
         n = 0;
         while (recovering === 1'b1 && n < 18 * HALF + 40) begin
            tick();
            n++;
         end
         host_sda_low = 1'b0;
         ok(low_phases == 9 && scl_oe === 1'b0, "nine recovery clocks");
         repeat (20) tick();
      end
      reg_write(OFS_CTRL, 8'h01, 1'b0);
      host_sda_low = 1'b1;
      wait_hi(1, SLOW + 60, n);
      ok(n == SLOW + 60, "watchdog disabled");
      ok(sda_o === 1'b0 && scl_o === 1'b0, "open-drain data low");
      host_sda_low = 1'b0;
      wrap_up();
   end
endmodule // control_channel_i2c_mapper_tb
